// file: inc/lcdrx_pkg.sv
// Constants shared by the LCD driver serial receiver front end.
// Assumes a single 100 MHz clock domain with synchronous pin inputs.
package lcdrx_pkg;
   localparam logic [5:0] LCDRX_ADDR_FIXED  = 6'h1C;
   localparam int         LCDRX_BYTE_BITS   = 8;
   localparam int         LCDRX_CONT_BIT    = 7;
   localparam int         LCDRX_RW_BIT      = 0;
   localparam int         LCDRX_SEL_BIT     = 1;
   localparam logic [2:0] LCDRX_BIT_LAST    = 3'h7;
   localparam int         LCDRX_SUB_W       = 3;
   localparam int         LCDRX_PTR_W       = 6;
   localparam logic [5:0] LCDRX_PTR_RESET   = 6'h00;
   localparam logic [2:0] LCDRX_SUB_RESET   = 3'h0;
   localparam logic [5:0] LCDRX_PTR_STEP    = 6'h01;
   localparam logic [2:0] LCDRX_SUB_STEP    = 3'h1;
   localparam logic [5:0] LCDRX_PTR_LAST    = 6'h3F;
   localparam int         LCDRX_FIFO_DEPTH  = 8;
   typedef enum logic [2:0] {
      LCDRX_IDLE, LCDRX_ADDR, LCDRX_CMD, LCDRX_DATA, LCDRX_IGNORE
   } lcdrx_phase_t;
endpackage : lcdrx_pkg

// file: verilog/lcdrx_top.sv
// Serial slave receiver front end of a segment LCD driver, with its output FIFO.
// Assumes scl and sda_in are already synchronous to clk and filtered.
//
// Summary of operation
// - Every byte is followed by one acknowledge clock before the next byte.
// - No byte count limit between start and stop.
// - Acknowledge the address and every command byte once addressed.
// - Hold SDA low across the whole high phase of the ack clock.
// - Slave receiver only; drives SDA solely for acknowledge bits.
// - Recognise addresses 0111000 and 0111001.
// - Address bit 1 must equal the address select pin level.
// - Read accesses are never answered; bit 0 must be zero.
// - Mismatched device ignores the transfer until the next start.
// - Commands continue while bit 7 is set; later bytes are display data.
// - Every selected device acknowledges each command byte.
// - Data bytes go to pointer and subaddress; the pointer then advances and carries into the subaddress.
// - Only matching hardware subaddress acknowledges display data.
// - Hardware subaddress is the binary value of three strap pins.
// - Stop ends the access; repeated start begins a new one.
// - Two addresses times eight subaddresses give sixteen separate devices.
// - Start and stop are detected at any time.
// - One bit per SCL pulse; SDA stable while SCL is high.
`timescale 1ns/1ps
`default_nettype none

module lcdrx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   always_comb begin
      push        = in_valid && (count != (AW+1)'(DEPTH));
      pop         = out_ready && (count != '0);
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1)) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1)) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         in_ready  <= next_count != (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end

   // Storage carries no reset so that it maps onto plain memory.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   assign out_data = mem[rd_ptr];
endmodule : lcdrx_fifo

module lcdrx_top
   import lcdrx_pkg::*;
#(
   parameter int PTR_W = LCDRX_PTR_W
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Serial link, SDA split into input, output and enable
   input  wire logic                   scl,
   input  wire logic                   sda_in,
   output logic                        sda_out,
   output logic                        sda_oe,
   // Straps
   input  wire logic                   addr_select_pin,
   input  wire logic                   hw_subaddr_bit0,
   input  wire logic                   hw_subaddr_bit1,
   input  wire logic                   hw_subaddr_bit2,
   // Command byte stream
   output logic                        cmd_valid,
   output logic [7:0]                  cmd_byte,
   // Display write stream, through the FIFO
   output logic                        ram_valid,
   input  wire logic                   ram_ready,
   output logic [7:0]                  ram_data,
   output logic [PTR_W-1:0]            ram_ptr,
   output logic [LCDRX_SUB_W-1:0]      ram_sub,
   // Pointer load from command decode
   input  wire logic                   ptr_load,
   input  wire logic [PTR_W-1:0]       ptr_value,
   input  wire logic                   sub_load,
   input  wire logic [LCDRX_SUB_W-1:0] sub_value,
   // Status
   output logic                        busy,
   output logic                        overflow
);
   localparam int FW = 8 + PTR_W + LCDRX_SUB_W;

   lcdrx_phase_t            phase, next_phase;
   logic                    scl_q, sda_q;
   logic [2:0]              bit_cnt, next_bit_cnt;
   logic [7:0]              shreg, next_shreg;
   logic                    in_ack, next_in_ack;
   logic                    ack_drv, next_ack_drv;
   logic                    last_cmd, next_last_cmd;
   logic [PTR_W-1:0]        ptr, next_ptr;
   logic [LCDRX_SUB_W-1:0]  sub, next_sub;
   logic                    next_cmd_valid;
   logic [7:0]              next_cmd_byte;
   logic                    next_overflow;
   logic                    f_push;
   logic [FW-1:0]           f_in;
   logic                    f_ready;
   logic                    f_valid;
   logic [FW-1:0]           f_out;
   logic [7:0]              byte_done;
   logic                    scl_rise, scl_fall, start_c, stop_c;
   logic [LCDRX_SUB_W-1:0]  hw_sub;
   logic                    ack_high, next_ack_high;
   logic                    next_sda_oe, next_busy, next_ram_valid;

   always_comb begin
      hw_sub    = {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
      scl_rise  = scl && !scl_q;
      scl_fall  = !scl && scl_q;
      start_c   = scl && scl_q && sda_q && !sda_in;
      stop_c    = scl && scl_q && !sda_q && sda_in;
      byte_done = {shreg[6:0], sda_in};
      next_phase     = phase;
      next_bit_cnt   = bit_cnt;
      next_shreg     = shreg;
      next_in_ack    = in_ack;
      next_ack_drv   = ack_drv;
      next_last_cmd  = last_cmd;
      next_ptr       = ptr_load ? ptr_value : ptr;
      next_sub       = sub_load ? sub_value : sub;
      next_cmd_valid = 1'b0;
      next_cmd_byte  = cmd_byte;
      next_overflow  = overflow;
      f_push         = 1'b0;
      f_in           = {shreg, ptr, sub};
      if (start_c) begin
         // repeated start opens a new access
         next_phase   = LCDRX_ADDR;
         next_bit_cnt = '0;
         next_in_ack  = 1'b0;
         next_ack_drv = 1'b0;
         next_last_cmd = 1'b0;
      end else if (stop_c) begin
         next_phase   = LCDRX_IDLE;
         next_ack_drv = 1'b0;
         next_in_ack  = 1'b0;
      end else if (phase != LCDRX_IDLE && phase != LCDRX_IGNORE) begin
         if (scl_rise && !in_ack) begin
            next_shreg   = byte_done;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == LCDRX_BIT_LAST) begin
               next_in_ack = 1'b1;
               case (phase)
                  LCDRX_ADDR: begin
                     if (byte_done[7:2] == LCDRX_ADDR_FIXED &&
                         byte_done[LCDRX_SEL_BIT] == addr_select_pin &&
                         !byte_done[LCDRX_RW_BIT]) begin
                        next_ack_drv = 1'b1;
                     end else begin
                        next_phase = LCDRX_IGNORE;
                     end
                  end
                  LCDRX_CMD: begin
                     next_ack_drv   = 1'b1;
                     next_cmd_valid = 1'b1;
                     next_cmd_byte  = byte_done;
                     next_last_cmd  = !byte_done[LCDRX_CONT_BIT];
                  end
                  LCDRX_DATA: begin
                     if (sub == hw_sub) begin
                        next_ack_drv = 1'b1;
                        f_push = 1'b1;
                        f_in   = {byte_done, ptr, sub};
                        if (!f_ready) begin
                           next_overflow = 1'b1;
                        end
                     end
                     next_ptr = ptr + PTR_W'(1);
                     if (ptr == {PTR_W{1'b1}}) begin
                        next_sub = sub + LCDRX_SUB_STEP;
                     end
                  end
                  default: begin
                     next_phase = LCDRX_IDLE;
                  end
               endcase
            end
         end
         if (scl_fall && in_ack && ack_high) begin
            next_in_ack = 1'b0;
            next_ack_drv = 1'b0;
            if (phase == LCDRX_ADDR) begin
               next_phase = LCDRX_CMD;
            end else if (phase == LCDRX_CMD && last_cmd) begin
               next_phase = LCDRX_DATA;
            end
         end
      end
   end

   // The ack slot ends on the fall that closes the ninth pulse; the first fall after
   // the eighth rise only starts the slot, so a flag records the ninth rise.
   always_comb begin
      next_ack_high = ack_high;
      if (start_c || stop_c || !in_ack) begin
         next_ack_high = 1'b0;
      end else if (scl_rise) begin
         next_ack_high = 1'b1;
      end else if (scl_fall && ack_high) begin
         next_ack_high = 1'b0;
      end
      next_sda_oe    = next_ack_drv && next_in_ack && in_ack && !(scl && !ack_high && !sda_oe);
      next_busy      = next_phase != LCDRX_IDLE;
      // An accepted word is masked for one cycle, so it is never presented twice.
      next_ram_valid = (ram_valid && ram_ready) ? 1'b0 : f_valid;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase     <= LCDRX_IDLE;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         bit_cnt   <= '0;
         shreg     <= '0;
         in_ack    <= 1'b0;
         ack_drv   <= 1'b0;
         ack_high  <= 1'b0;
         last_cmd  <= 1'b0;
         ptr       <= '0;
         sub       <= LCDRX_SUB_RESET;
         cmd_valid <= 1'b0;
         cmd_byte  <= '0;
         overflow  <= 1'b0;
         sda_oe    <= 1'b0;
         sda_out   <= 1'b0;
         busy      <= 1'b0;
         ram_ptr   <= '0;
         ram_sub   <= '0;
         ram_data  <= '0;
         ram_valid <= 1'b0;
      end else begin
         phase     <= next_phase;
         scl_q     <= scl;
         sda_q     <= sda_in;
         bit_cnt   <= next_bit_cnt;
         shreg     <= next_shreg;
         in_ack    <= next_in_ack;
         ack_drv   <= next_ack_drv;
         ack_high  <= next_ack_high;
         last_cmd  <= next_last_cmd;
         ptr       <= next_ptr;
         sub       <= next_sub;
         cmd_valid <= next_cmd_valid;
         cmd_byte  <= next_cmd_byte;
         overflow  <= next_overflow;
         sda_oe    <= next_sda_oe;
         sda_out   <= 1'b0;
         busy      <= next_busy;
         ram_valid <= next_ram_valid;
         ram_data  <= f_out[FW-1 -: 8];
         ram_ptr   <= f_out[LCDRX_SUB_W +: PTR_W];
         ram_sub   <= f_out[LCDRX_SUB_W-1:0];
      end
   end

   // The FIFO head is registered once more so that every display output is a flop.
   lcdrx_fifo #(
      .WIDTH (FW),
      .DEPTH (LCDRX_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (f_push),
      .in_ready  (f_ready),
      .in_data   (f_in),
      .out_valid (f_valid),
      .out_ready (ram_ready && ram_valid),
      .out_data  (f_out)
   );
endmodule : lcdrx_top

`default_nettype wire

// file: sim/lcdrx_master_model.sv
// Behavioural serial bus master that writes to the receiver.
// Assumes the bench resolves SDA from both pull-down drivers and a pull-up.
`timescale 1ns/1ps
`default_nettype none
module lcdrx_master_model (
   // Clock
   input  wire logic clk,
   // Bus
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl     = 1'h1;
      sda_low = 1'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic start_cond();
      sda_low = 1'h0;
      tick(4);
      scl = 1'h1;
      tick(8);
      sda_low = 1'h1;
      tick(8);
      scl = 1'h0;
      tick(4);
   endtask : start_cond
   task automatic stop_cond();
      sda_low = 1'h1;
      tick(4);
      scl = 1'h1;
      tick(8);
      sda_low = 1'h0;
      tick(8);
   endtask : stop_cond
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~b[i];
         tick(4);
         scl = 1'h1;
         tick(8);
         scl = 1'h0;
         tick(4);
      end
      sda_low = 1'h0;
      tick(4);
      scl = 1'h1;
      tick(4);
      ack = ~sda_wire;
      tick(4);
      scl = 1'h0;
      tick(4);
   endtask : send_byte
endmodule : lcdrx_master_model
`default_nettype wire

// file: sim/lcdrx_sva.sv
// Concurrent checks on the receiver front end ports.
// Assumes it is bound onto every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module lcdrx_sva
   import lcdrx_pkg::*;
#(
   parameter int PTR_W = LCDRX_PTR_W
) (
   // Clock and reset
   input wire logic             clk,
   input wire logic             reset,
   // Serial link
   input wire logic             scl,
   input wire logic             sda_in,
   input wire logic             sda_out,
   input wire logic             sda_oe,
   // Streams and status
   input wire logic             cmd_valid,
   input wire logic             ram_valid,
   input wire logic             ram_ready,
   input wire logic [7:0]       ram_data,
   input wire logic [PTR_W-1:0] ram_ptr,
   input wire logic             busy,
   input wire logic             overflow
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_drive_low_only: assert property (sda_out == 1'h0)
      else $error("sda_out not held low");
   a_ack_steady_high: assert property (scl && $past(scl) |-> $stable(sda_oe))
      else $error("sda_oe moved while scl high");
   a_ack_rise_low: assert property ($rose(sda_oe) |-> !scl && busy)
      else $error("ack began outside a low clock phase");
   a_idle_no_ack: assert property (!busy |-> !sda_oe)
      else $error("ack driven while idle");
   a_start_wakes: assert property (scl && $past(scl) && $fell(sda_in) |-> ##[1:6] busy)
      else $error("start not detected");
   a_stop_idles: assert property (scl && $past(scl) && $rose(sda_in) |-> ##[1:6] !busy)
      else $error("stop did not return to idle");
   a_cmd_one_cycle: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse too long");
   a_ram_holds: assert property (ram_valid && !ram_ready |=> ram_valid && $stable(ram_data) && $stable(ram_ptr))
      else $error("display word changed before acceptance");
   a_overflow_sticky: assert property (overflow |=> overflow)
      else $error("overflow flag cleared without reset");
   a_reset_quiet: assert property (disable iff (1'h0) reset |-> !sda_oe && !cmd_valid && !ram_valid && !busy)
      else $error("outputs active in reset");
   cover property ($rose(sda_oe));
   cover property (cmd_valid);
   cover property (ram_valid && ram_ready);
   cover property ($rose(overflow));
endmodule : lcdrx_sva
bind lcdrx_top lcdrx_sva #(.PTR_W(PTR_W)) u_sva (.clk, .reset, .scl, .sda_in, .sda_out, .sda_oe, .cmd_valid,
   .ram_valid, .ram_ready, .ram_data, .ram_ptr, .busy, .overflow);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the receiver front end and its FIFO.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lcdrx_pkg::*;
   logic       clk, reset, scl, sda_low, sda_wire, sda_out, sda_oe, sel;
   logic       cmd_valid, ram_valid, ram_ready, ptr_load, sub_load, busy, overflow;
   logic [2:0] hw, ram_sub, sub_value;
   logic [5:0] ram_ptr, ptr_value;
   logic [7:0] cmd_byte, ram_data, last_cmd;
   int         fail_count, cmp_count, cmd_cnt;
   // The line is pulled up; either party may only pull it low.
   assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));
   lcdrx_master_model mst (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
   lcdrx_top uut (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin(sel), .hw_subaddr_bit0(hw[0]), .hw_subaddr_bit1(hw[1]), .hw_subaddr_bit2(hw[2]),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .ram_valid(ram_valid), .ram_ready(ram_ready),
      .ram_data(ram_data), .ram_ptr(ram_ptr), .ram_sub(ram_sub), .ptr_load(ptr_load), .ptr_value(ptr_value),
      .sub_load(sub_load), .sub_value(sub_value), .busy(busy), .overflow(overflow));
   always @(posedge clk) if (cmd_valid === 1'h1) begin
      cmd_cnt  <= cmd_cnt + 1;
      last_cmd <= cmd_byte;
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic [7:0] b, input logic exp);
      logic a;
      mst.send_byte(b, a);
      chk({7'h0, a}, {7'h0, exp});
   endtask : xfer
   task automatic set_ptr(input logic [5:0] p, input logic [2:0] s);
      ptr_value = p;
      sub_value = s;
      ptr_load  = 1'h1;
      sub_load  = 1'h1;
      mst.tick(1);
      ptr_load  = 1'h0;
      sub_load  = 1'h0;
   endtask : set_ptr
   task automatic drain(input logic [7:0] d, input logic [5:0] p, input logic [2:0] s);
      int n;
      n = 0;
      while (ram_valid !== 1'h1 && n < 50) begin
         mst.tick(1);
         n++;
      end
      chk(ram_data, d);
      chk({2'h0, ram_ptr}, {2'h0, p});
      chk({5'h0, ram_sub}, {5'h0, s});
      ram_ready = 1'h1;
      mst.tick(1);
      ram_ready = 1'h0;
      mst.tick(1);
   endtask : drain
   task automatic t_stream();
      int base;
      base = cmd_cnt;
      set_ptr(6'h00, 3'h0);
      mst.start_cond();
      xfer(8'h70, 1'h1);
      xfer(8'hE0, 1'h1);
      xfer(8'h60, 1'h1);
      for (int i = 0; i < 9; i++) xfer(8'h10 + i[7:0], 1'h1);
      mst.stop_cond();
      chk({7'h0, busy}, 8'h00);
      chk(8'(cmd_cnt - base), 8'h02);
      chk(last_cmd, 8'h60);
      chk({7'h0, overflow}, 8'h01);
      for (int i = 0; i < 8; i++) drain(8'h10 + i[7:0], i[5:0], 3'h0);
      chk({7'h0, ram_valid}, 8'h00);
   endtask : t_stream
   task automatic t_reject();
      int base;
      base = cmd_cnt;
      for (int k = 0; k < 4; k++) begin
         sel = k[0];
         mst.start_cond();
         xfer({6'h1C, k[1], 1'h0}, k[1] == k[0]);
         xfer(8'h00, k[1] == k[0]);
         mst.stop_cond();
      end
      sel = 1'h0;
      mst.start_cond();
      xfer(8'h71, 1'h0);
      xfer(8'h00, 1'h0);
      mst.stop_cond();
      chk(8'(cmd_cnt - base), 8'h02);
   endtask : t_reject
   task automatic t_subaddr();
      hw = 3'h5;
      set_ptr(6'h3F, 3'h5);
      mst.start_cond();
      xfer(8'h70, 1'h1);
      xfer(8'h00, 1'h1);
      xfer(8'hA5, 1'h1);
      xfer(8'h5A, 1'h0);
      mst.start_cond();
      xfer(8'h70, 1'h1);
      xfer(8'h00, 1'h1);
      xfer(8'hC3, 1'h0);
      mst.stop_cond();
      drain(8'hA5, 6'h3F, 3'h5);
      chk({7'h0, ram_valid}, 8'h00);
      hw = 3'h0;
   endtask : t_subaddr
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      reset = 1'h1;
      sel = 1'h0;
      hw = 3'h0;
      ram_ready = 1'h0;
      ptr_load = 1'h0;
      sub_load = 1'h0;
      ptr_value = 6'h00;
      sub_value = 3'h0;
      fail_count = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      #1 reset = 1'h0;
      mst.tick(2);
      t_stream();
      t_reject();
      t_subaddr();
      complete_run();
   end
   initial begin
      repeat (50000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule : tb
`default_nettype wire
